// *** shc_homing_map.vh ***
// object dictionary indices, field positions, reset values and codes
// for the homing controller; included by shc_homing.v only
`ifndef SHC_HOMING_MAP_VH
`define SHC_HOMING_MAP_VH

`define SHC_IDX_POL_MASK   16'h2021
`define SHC_IDX_ERR_CODE   16'h2022
`define SHC_IDX_CTRL       16'h6040
`define SHC_IDX_STAT       16'h6041
`define SHC_IDX_MODE_SEL   16'h6060
`define SHC_IDX_MODE_DISP  16'h6061
`define SHC_IDX_OFFSET     16'h607c
`define SHC_IDX_METHOD     16'h6098
`define SHC_IDX_SPEEDS     16'h6099
`define SHC_IDX_ACCEL      16'h609a

`define SHC_CW_START       4
`define SHC_CW_HALT        8
`define SHC_SW_TARGET      10
`define SHC_SW_ATTAINED    12
`define SHC_SW_ERROR       13

`define SHC_IN_RIGHT       4
`define SHC_IN_LEFT        5
`define SHC_IN_REF         6

`define SHC_PARAM_HOMING   8'hc8
`define SHC_MODE_PP        8'h01
`define SHC_MODE_HM        8'h06
`define SHC_MODE_IP        8'h07
`define SHC_MODE_NONE      8'h00

`define SHC_METH_STD_MAX   8'h23
`define SHC_METH_IDX_NEG   8'h21
`define SHC_METH_IDX_POS   8'h22
`define SHC_METH_CUR_POS   8'h23
`define SHC_METH_SW_LAST   8'h0e
`define SHC_METH_NOIDX_LO  8'h11
`define SHC_METH_NOIDX_HI  8'h1e

`define SHC_SPEED_ENTRIES  32'h0000_0002
`define SHC_RST_OFFSET     32'h0000_0000
`define SHC_RST_METHOD     8'h00
`define SHC_RST_WORD16     16'h0000
`define SHC_RST_WORD32     32'h0000_0000

`define SHC_ERR_NONE       16'h0000
`define SHC_ERR_METHOD     16'h0001
`define SHC_ERR_LIMIT      16'h0002

`endif

// *** shc_homing.v ***
// homing controller: mode display, homing sequencer, object dictionary
// assumes od_* requests come from fieldbus logic on core_clk; switch and
// index pins are asynchronous; position feedback is on core_clk
`timescale 1ns/1ns
`include "shc_homing_map.vh"

module shc_homing
(
  input  wire        core_clk,
  input  wire        rst_n,
  input  wire [15:0] od_index,
  input  wire [7:0]  od_subindex,
  input  wire        od_wr,
  input  wire        od_rd,
  input  wire [31:0] od_wdata,
  output reg  [31:0] od_rdata_q,
  output reg         od_ack_q,
  output reg         od_err_q,
  input  wire [7:0]  operating_mode_param,
  input  wire        right_limit_input,
  input  wire        left_limit_input,
  input  wire        reference_switch_input,
  input  wire        index_pulse,
  input  wire [31:0] position_fbk,
  input  wire        axle_stopped,
  output reg         move_en_q,
  output reg         move_dir_neg_q,
  output reg  [31:0] move_speed_q,
  output reg  [31:0] move_accel_q,
  output reg  [31:0] zero_pos_q,
  output reg         zero_load_q
);

  localparam [2:0] ST_IDLE   = 3'd0;
  localparam [2:0] ST_SWITCH = 3'd1;
  localparam [2:0] ST_INDEX  = 3'd2;
  localparam [2:0] ST_DONE   = 3'd3;
  reg  [15:0] pol_mask_q;
  reg  [15:0] ctrl_q;
  reg  [7:0]  mode_sel_q;
  reg  [7:0]  mode_disp_q;
  reg  [31:0] offset_q;
  reg  [7:0]  method_q;
  reg  [31:0] speed_fast_q;
  reg  [31:0] speed_slow_q;
  reg  [31:0] accel_q;
  reg  [15:0] err_code_q;
  reg         attained_q;
  reg         error_q;
  reg  [2:0]  state_q;
  reg  [3:0]  pin_s1_q;
  reg  [3:0]  pin_s2_q;
  reg         index_prev_q;
  reg         start_prev_q;
  reg  [7:0]  mode_disp_d;
  reg  [15:0] status_w;
  reg  [31:0] rd_w;
  reg         hit_w;
  reg         ro_w;
  wire        homing_mode = (mode_disp_q == `SHC_MODE_HM);
  wire        start_bit = ctrl_q[`SHC_CW_START];
  wire        halt_bit = ctrl_q[`SHC_CW_HALT];
  wire        start_rise = start_bit & ~start_prev_q;
  wire        start_fall = ~start_bit & start_prev_q;
  wire [2:0]  sw_in;
  wire        right_act = sw_in[0];
  wire        left_act = sw_in[1];
  wire        ref_act = sw_in[2];
  wire        index_rise = pin_s2_q[3] & ~index_prev_q;
  wire        meth_neg = method_q[7];
  wire        meth_std = (|method_q) && (method_q <= `SHC_METH_STD_MAX);
  wire        meth_reserved = (method_q == 8'h0f) || (method_q == 8'h10) ||
                              (method_q == 8'h1f) || (method_q == 8'h20);
  wire        meth_noidx = (method_q >= `SHC_METH_NOIDX_LO) &&
                           (method_q <= `SHC_METH_NOIDX_HI);
  wire [31:0] zero_sum = position_fbk + offset_q;

  // per-input polarity: mask bits 4..6 flip the synchronised level
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1)
    begin : g_pol
      assign sw_in[gi] = pin_s2_q[gi] ^ pol_mask_q[`SHC_IN_RIGHT + gi];
    end
  endgenerate

  // pins are asynchronous: two flops before anything reads them
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_s1_q     <= 4'h0;
      pin_s2_q     <= 4'h0;
      index_prev_q <= 1'b0;
    end
    else
    begin
      pin_s1_q     <= {index_pulse, reference_switch_input,
                       left_limit_input, right_limit_input};
      pin_s2_q     <= pin_s1_q;
      index_prev_q <= pin_s2_q[3];
    end
  end

  // parameter 200 forces homing; a bad selection keeps the mode in force
  always @*
  begin
    mode_disp_d = mode_disp_q;
    if (operating_mode_param == `SHC_PARAM_HOMING)
      mode_disp_d = `SHC_MODE_HM;
    else if (mode_sel_q == `SHC_MODE_PP || mode_sel_q == `SHC_MODE_HM ||
             mode_sel_q == `SHC_MODE_IP)
      mode_disp_d = mode_sel_q;
  end

  always @*
  begin
    status_w = `SHC_RST_WORD16;
    status_w[`SHC_SW_TARGET] = halt_bit ? axle_stopped : attained_q;
    status_w[`SHC_SW_ATTAINED] = attained_q;
    status_w[`SHC_SW_ERROR] = error_q;
  end
  // read mux and address decode
  always @*
  begin
    rd_w  = `SHC_RST_WORD32;
    hit_w = 1'b1;
    ro_w  = 1'b0;
    if (od_index == `SHC_IDX_POL_MASK)
      rd_w = {16'h0000, pol_mask_q};
    else if (od_index == `SHC_IDX_ERR_CODE)
    begin
      rd_w = {16'h0000, err_code_q};
      ro_w = 1'b1;
    end
    else if (od_index == `SHC_IDX_CTRL)
      rd_w = {16'h0000, ctrl_q};
    else if (od_index == `SHC_IDX_STAT)
    begin
      rd_w = {16'h0000, status_w};
      ro_w = 1'b1;
    end
    else if (od_index == `SHC_IDX_MODE_SEL)
      rd_w = {{24{mode_sel_q[7]}}, mode_sel_q};
    else if (od_index == `SHC_IDX_MODE_DISP)
    begin
      rd_w = {{24{mode_disp_q[7]}}, mode_disp_q};
      ro_w = 1'b1;
    end
    else if (od_index == `SHC_IDX_OFFSET)
      rd_w = offset_q;
    else if (od_index == `SHC_IDX_METHOD)
      rd_w = {{24{method_q[7]}}, method_q};
    else if (od_index == `SHC_IDX_SPEEDS && od_subindex == 8'h00)
    begin
      rd_w = `SHC_SPEED_ENTRIES;
      ro_w = 1'b1;
    end
    else if (od_index == `SHC_IDX_SPEEDS && od_subindex == 8'h01)
      rd_w = speed_fast_q;
    else if (od_index == `SHC_IDX_SPEEDS && od_subindex == 8'h02)
      rd_w = speed_slow_q;
    else if (od_index == `SHC_IDX_ACCEL)
      rd_w = accel_q;
    else
      hit_w = 1'b0;
  end

  // one-cycle answer to every request; unmapped or read-only write errs
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      od_rdata_q <= `SHC_RST_WORD32;
      od_ack_q   <= 1'b0;
      od_err_q   <= 1'b0;
    end
    else
    begin
      od_ack_q   <= od_wr | od_rd;
      od_err_q   <= (od_wr | od_rd) & (~hit_w | (od_wr & ro_w));
      od_rdata_q <= (od_rd && hit_w) ? rd_w : `SHC_RST_WORD32;
    end
  end

  // writes land at any time: set method, speeds, accel before start
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pol_mask_q   <= `SHC_RST_WORD16;
      ctrl_q       <= `SHC_RST_WORD16;
      mode_sel_q   <= `SHC_MODE_NONE;
      offset_q     <= `SHC_RST_OFFSET;
      method_q     <= `SHC_RST_METHOD;
      speed_fast_q <= `SHC_RST_WORD32;
      speed_slow_q <= `SHC_RST_WORD32;
      accel_q      <= `SHC_RST_WORD32;
    end
    else if (od_wr && hit_w && !ro_w)
    begin
      if (od_index == `SHC_IDX_POL_MASK)
        pol_mask_q <= od_wdata[15:0];
      else if (od_index == `SHC_IDX_CTRL)
        ctrl_q <= od_wdata[15:0];
      else if (od_index == `SHC_IDX_MODE_SEL)
        mode_sel_q <= od_wdata[7:0];
      else if (od_index == `SHC_IDX_OFFSET)
        offset_q <= od_wdata;
      else if (od_index == `SHC_IDX_METHOD)
        method_q <= od_wdata[7:0];
      else if (od_index == `SHC_IDX_SPEEDS && od_subindex == 8'h01)
        speed_fast_q <= od_wdata;
      else if (od_index == `SHC_IDX_SPEEDS)
        speed_slow_q <= od_wdata;
      else if (od_index == `SHC_IDX_ACCEL)
        accel_q <= od_wdata;
    end
  end

  // homing sequencer: status bits, error code, loop demand and zero preset leave it
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q        <= ST_IDLE;
      mode_disp_q    <= `SHC_MODE_NONE;
      start_prev_q   <= 1'b0;
      attained_q     <= 1'b0;
      error_q        <= 1'b0;
      err_code_q     <= `SHC_ERR_NONE;
      move_en_q      <= 1'b0;
      move_dir_neg_q <= 1'b0;
      move_speed_q   <= `SHC_RST_WORD32;
      move_accel_q   <= `SHC_RST_WORD32;
      zero_pos_q     <= `SHC_RST_WORD32;
      zero_load_q    <= 1'b0;
    end
    else
    begin
      mode_disp_q  <= mode_disp_d;
      start_prev_q <= start_bit;
      zero_load_q  <= 1'b0;
      move_accel_q <= accel_q;
      if (!homing_mode || start_fall)
      begin
        // leaving homing or a falling start bit abandons the run
        state_q    <= ST_IDLE;
        move_en_q  <= 1'b0;
        if (state_q != ST_IDLE || start_fall)
          attained_q <= 1'b0;
      end
      else if (start_rise)
      begin
        attained_q <= 1'b0;
        error_q    <= 1'b0;
        err_code_q <= `SHC_ERR_NONE;
        if (meth_neg || method_q == `SHC_METH_CUR_POS)
        begin
          // preset on the spot, no axis motion
          zero_pos_q  <= zero_sum;
          zero_load_q <= 1'b1;
          attained_q  <= 1'b1;
          state_q     <= ST_DONE;
        end
        else if (!meth_std || meth_reserved)
        begin
          error_q    <= 1'b1;
          err_code_q <= `SHC_ERR_METHOD;
          state_q    <= ST_DONE;
        end
        else if (method_q == `SHC_METH_IDX_NEG ||
                 method_q == `SHC_METH_IDX_POS)
        begin
          move_dir_neg_q <= (method_q == `SHC_METH_IDX_NEG);
          move_speed_q   <= speed_slow_q;
          state_q        <= ST_INDEX;
        end
        else
        begin
          move_dir_neg_q <= method_q[0];
          move_speed_q   <= speed_fast_q;
          state_q        <= ST_SWITCH;
        end
      end
      else
      begin
        // halt drops the demand; the loops ramp down at move_accel_q
        move_en_q <= ~halt_bit &&
                     (state_q == ST_SWITCH || state_q == ST_INDEX);
        case (state_q)
          ST_SWITCH:
          begin
            if (!halt_bit)
            begin
              if ((move_dir_neg_q ? left_act : right_act) && !ref_act &&
                  method_q > `SHC_METH_SW_LAST && !meth_noidx)
              begin
                error_q    <= 1'b1;
                err_code_q <= `SHC_ERR_LIMIT;
                state_q    <= ST_DONE;
              end
              else if (ref_act || (move_dir_neg_q ? left_act : right_act))
              begin
                if (meth_noidx)
                begin
                  zero_pos_q  <= zero_sum;
                  zero_load_q <= 1'b1;
                  attained_q  <= 1'b1;
                  state_q     <= ST_DONE;
                end
                else
                begin
                  // slow back off the switch toward the index
                  move_dir_neg_q <= ~move_dir_neg_q;
                  move_speed_q   <= speed_slow_q;
                  state_q        <= ST_INDEX;
                end
              end
            end
          end
          ST_INDEX:
          begin
            if (!halt_bit && index_rise)
            begin
              zero_pos_q  <= zero_sum;
              zero_load_q <= 1'b1;
              attained_q  <= 1'b1;
              state_q     <= ST_DONE;
            end
            else if (!halt_bit && (move_dir_neg_q ? left_act : right_act))
            begin
              error_q    <= 1'b1;
              err_code_q <= `SHC_ERR_LIMIT;
              state_q    <= ST_DONE;
            end
          end
          ST_DONE:
            move_en_q <= 1'b0;
          default:
            state_q <= ST_IDLE;
        endcase
      end
    end
  end
endmodule

// *** shc_homing_chk.sv ***
// checker for the homing controller object bus and motion outputs
// bound to shc_homing; sees its ports only, single clock domain
`timescale 1ns/1ns
module shc_homing_chk
(
  input logic        core_clk,
  input logic        rst_n,
  input logic [15:0] od_index,
  input logic        od_wr,
  input logic        od_rd,
  input logic [31:0] od_wdata,
  input logic        od_ack_q,
  input logic        od_err_q,
  input logic [31:0] position_fbk,
  input logic        move_en_q,
  input logic [31:0] move_accel_q,
  input logic [31:0] zero_pos_q,
  input logic        zero_load_q
);
  // shadow of the offset entry, lands on the same edge as the entry
  logic [31:0] off_q;
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      off_q <= 32'h0000_0000;
    else if (od_wr && od_index == 16'h607c)
      off_q <= od_wdata;
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  chk_ack_after_req:
    assert property ((od_wr || od_rd) |=> od_ack_q)
    else $error("no answer after request");
  chk_no_stray_ack:
    assert property (!(od_wr || od_rd) |=> !od_ack_q)
    else $error("answer without request");
  chk_err_with_ack:
    assert property (od_err_q |-> od_ack_q)
    else $error("error flag without answer");
  chk_display_ro:
    assert property (od_wr && od_index == 16'h6061 |=> od_err_q)
    else $error("display write not refused");
  chk_method_write_ok:
    assert property (od_wr && od_index == 16'h6098 |=> !od_err_q)
    else $error("method write refused");
  chk_accel_to_demand:
    assert property (od_wr && od_index == 16'h609a |=> ##1
                     move_accel_q == $past(od_wdata, 2))
    else $error("acceleration demand not updated");
  chk_zero_load_pulse:
    assert property (zero_load_q |=> !zero_load_q)
    else $error("zero load longer than one cycle");
  chk_zero_pos_sum:
    assert property (zero_load_q |->
                     zero_pos_q == $past(position_fbk) + $past(off_q))
    else $error("zero position not home plus offset");
  chk_load_stops_move:
    assert property (zero_load_q |=> !move_en_q)
    else $error("motion continues after home found");
  cover property (zero_load_q);
  cover property (od_ack_q && od_err_q);
  cover property ($rose(move_en_q));
endmodule

bind shc_homing shc_homing_chk u_chk
(
  .core_clk(core_clk), .rst_n(rst_n), .od_index(od_index),
  .od_wr(od_wr), .od_rd(od_rd), .od_wdata(od_wdata),
  .od_ack_q(od_ack_q), .od_err_q(od_err_q),
  .position_fbk(position_fbk), .move_en_q(move_en_q),
  .move_accel_q(move_accel_q), .zero_pos_q(zero_pos_q),
  .zero_load_q(zero_load_q)
);

// *** shc_axle_model.sv ***
// axle and encoder stand-in: integrates the motion demand
// assumes one count per clock while motion is demanded
`timescale 1ns/1ns
module shc_axle_model
(
  input  logic        core_clk,
  input  logic        rst_n,
  input  logic        move_en_q,
  input  logic        move_dir_neg_q,
  output logic [31:0] position_fbk,
  output logic        axle_stopped,
  output logic        index_pulse
);
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      position_fbk <= 32'h0000_0105;
      axle_stopped <= 1'b1;
      index_pulse  <= 1'b0;
    end
    else
    begin
      if (move_en_q && move_dir_neg_q)
        position_fbk <= position_fbk - 32'h1;
      else if (move_en_q)
        position_fbk <= position_fbk + 32'h1;
      axle_stopped <= !move_en_q;
      // one index per 16 counts, only while turning
      index_pulse <= move_en_q && (position_fbk[3:0] == 4'h0);
    end
  end
endmodule

// *** tb.sv ***
// self-checking bench for the homing controller
// bus driven at the falling edge; axle model closes the motion loop
`timescale 1ns/1ns
module tb;
  logic        core_clk;
  logic        rst_n;
  logic [15:0] od_index;
  logic [7:0]  od_subindex;
  logic        od_wr;
  logic        od_rd;
  logic [31:0] od_wdata;
  logic [31:0] od_rdata_q;
  logic        od_ack_q;
  logic        od_err_q;
  logic [7:0]  operating_mode_param;
  logic        right_limit_input;
  logic        left_limit_input;
  logic        reference_switch_input;
  logic        index_pulse;
  logic [31:0] position_fbk;
  logic        axle_stopped;
  logic        move_en_q;
  logic        move_dir_neg_q;
  logic [31:0] move_speed_q;
  logic [31:0] move_accel_q;
  logic [31:0] zero_pos_q;
  logic        zero_load_q;
  logic [31:0] d;
  logic        e;
  int          n_fail = 0;
  int          total_checks = 0;

  shc_homing dut
  (
    .core_clk(core_clk), .rst_n(rst_n), .od_index(od_index),
    .od_subindex(od_subindex), .od_wr(od_wr), .od_rd(od_rd),
    .od_wdata(od_wdata), .od_rdata_q(od_rdata_q),
    .od_ack_q(od_ack_q), .od_err_q(od_err_q),
    .operating_mode_param(operating_mode_param),
    .right_limit_input(right_limit_input),
    .left_limit_input(left_limit_input),
    .reference_switch_input(reference_switch_input),
    .index_pulse(index_pulse), .position_fbk(position_fbk),
    .axle_stopped(axle_stopped), .move_en_q(move_en_q),
    .move_dir_neg_q(move_dir_neg_q), .move_speed_q(move_speed_q),
    .move_accel_q(move_accel_q), .zero_pos_q(zero_pos_q),
    .zero_load_q(zero_load_q)
  );

  shc_axle_model u_axle
  (
    .core_clk(core_clk), .rst_n(rst_n), .move_en_q(move_en_q),
    .move_dir_neg_q(move_dir_neg_q), .position_fbk(position_fbk),
    .axle_stopped(axle_stopped), .index_pulse(index_pulse)
  );

  task automatic wrap_up;
    if (n_fail == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one request, answer taken the cycle after
  task automatic acc(input logic [15:0] i, input logic [7:0] s,
                     input logic w, input logic [31:0] v);
    @(negedge core_clk);
    od_index = i;
    od_subindex = s;
    od_wr = w;
    od_rd = !w;
    od_wdata = v;
    @(negedge core_clk);
    od_wr = 1'b0;
    od_rd = 1'b0;
    d = od_rdata_q;
    e = od_err_q;
    chk(od_ack_q, 1'b1);
  endtask

  task automatic wr(input logic [15:0] i, input logic [31:0] v);
    acc(i, 8'h00, 1'b1, v);
  endtask

  task automatic rd(input logic [15:0] i);
    acc(i, 8'h00, 1'b0, 32'h0);
  endtask

  // bounded wait on zero load (sel) or motion demand
  task automatic wait_for(input logic sel);
    int k;
    k = 0;
    while ((sel ? zero_load_q : move_en_q) !== 1'b1 && k < 60)
    begin
      @(negedge core_clk);
      k++;
    end
    chk(sel ? zero_load_q : move_en_q, 1'b1);
  endtask

  task automatic t_reset;
    rd(16'h607c);
    chk(d, 32'h0);
    rd(16'h6098);
    chk(d, 32'h0);
    rd(16'h6061);
    chk(d, 32'h0);
    rd(16'h6099);
    chk(d, 32'h2);
  endtask

  task automatic t_regs;
    wr(16'h607c, 32'hffff_ff00);
    rd(16'h607c);
    chk(d, 32'hffff_ff00);
    wr(16'h6098, 32'h0000_00ff);
    rd(16'h6098);
    chk(d, 32'hffff_ffff);
    acc(16'h6099, 8'h01, 1'b1, 32'h40);
    acc(16'h6099, 8'h02, 1'b1, 32'h08);
    acc(16'h6099, 8'h02, 1'b0, 32'h0);
    chk(d, 32'h08);
    wr(16'h609a, 32'h33);
    rd(16'h609a);
    chk(d, 32'h33);
    wr(16'h6061, 32'h6);
    chk(e, 1'b1);
    wr(16'h6041, 32'h0);
    chk(e, 1'b1);
    rd(16'h1234);
    chk(e, 1'b1);
  endtask

  task automatic t_mode;
    logic [7:0] sel [4] = '{8'h01, 8'h07, 8'h03, 8'h06};
    logic [7:0] shown [4] = '{8'h01, 8'h07, 8'h07, 8'h06};
    for (int k = 0; k < 4; k++)
    begin
      wr(16'h6060, {24'h0, sel[k]});
      rd(16'h6061);
      chk(d, {24'h0, shown[k]});
    end
    wr(16'h6060, 32'h1);
    operating_mode_param = 8'hc8;
    rd(16'h6061);
    chk(d, 32'h6);
    operating_mode_param = 8'h00;
  endtask

  task automatic t_ignore;
    wr(16'h6060, 32'h1);
    wr(16'h6040, 32'h10);
    repeat (3) @(negedge core_clk);
    rd(16'h6041);
    chk(d, 32'h0);
    wr(16'h6040, 32'h0);
  endtask

  task automatic t_preset;
    wr(16'h6060, 32'h6);
    wr(16'h6098, 32'hff);
    wr(16'h607c, 32'h100);
    wr(16'h6040, 32'h10);
    wait_for(1'b1);
    chk(zero_pos_q, position_fbk + 32'h100);
    chk(move_en_q, 1'b0);
    rd(16'h6041);
    chk(d, 32'h1400);
    wr(16'h6040, 32'h0);
    rd(16'h6041);
    chk(d, 32'h0);
    wr(16'h6040, 32'h100);
    rd(16'h6041);
    chk(d, 32'h0400);
    wr(16'h6040, 32'h0);
  endtask

  task automatic t_fail;
    logic [7:0] m [3] = '{8'h00, 8'h0f, 8'h24};
    for (int k = 0; k < 3; k++)
    begin
      wr(16'h6098, {24'h0, m[k]});
      wr(16'h6040, 32'h10);
      repeat (2) @(negedge core_clk);
      rd(16'h6041);
      chk(d, 32'h2000);
      rd(16'h2022);
      chk(d, 32'h1);
      wr(16'h6040, 32'h0);
    end
    wr(16'h6098, 32'hff);
    wr(16'h6040, 32'h10);
    wait_for(1'b1);
    rd(16'h6041);
    chk(d, 32'h1400);
    wr(16'h6040, 32'h0);
  endtask

  // left limit made active by the mask alone, pins at rest
  task automatic t_limit;
    wr(16'h2021, 32'h20);
    wr(16'h6098, 32'h21);
    wr(16'h6040, 32'h10);
    repeat (8) @(negedge core_clk);
    rd(16'h6041);
    chk(d, 32'h2000);
    rd(16'h2022);
    chk(d, 32'h2);
    wr(16'h6040, 32'h0);
    wr(16'h2021, 32'h0);
  endtask

  task automatic t_index;
    for (int k = 0; k < 2; k++)
    begin
      wr(16'h6098, k ? 32'h21 : 32'h22);
      wr(16'h6040, 32'h10);
      wait_for(1'b0);
      chk(move_dir_neg_q, k[0]);
      chk(move_speed_q, 32'h08);
      chk(move_accel_q, 32'h33);
      wait_for(1'b1);
      repeat (2) @(negedge core_clk);
      chk(move_en_q, 1'b0);
      rd(16'h6041);
      chk(d, 32'h1400);
      wr(16'h6040, 32'h0);
    end
  endtask

  // fast switch search, halt and resume, slow reverse onto the index
  task automatic t_switch;
    wr(16'h6098, 32'h04);
    wr(16'h6040, 32'h10);
    wait_for(1'b0);
    chk(move_speed_q, 32'h40);
    chk(move_dir_neg_q, 1'b0);
    wr(16'h6040, 32'h110);
    rd(16'h6041);
    chk(d, 32'h0);
    rd(16'h6041);
    chk(d, 32'h0400);
    chk(move_en_q, 1'b0);
    wr(16'h6040, 32'h10);
    reference_switch_input = 1'b1;
    repeat (4) @(negedge core_clk);
    chk(move_speed_q, 32'h08);
    chk(move_dir_neg_q, 1'b1);
    reference_switch_input = 1'b0;
    wait_for(1'b1);
    rd(16'h6041);
    chk(d, 32'h1400);
    wr(16'h6040, 32'h0);
  endtask

  initial
  begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  initial
  begin
    #200000;
    n_fail++;
    wrap_up;
  end

  initial
  begin
    od_index = 16'h0;
    od_subindex = 8'h0;
    od_wr = 1'b0;
    od_rd = 1'b0;
    od_wdata = 32'h0;
    operating_mode_param = 8'h00;
    right_limit_input = 1'b0;
    left_limit_input = 1'b0;
    reference_switch_input = 1'b0;
    rst_n = 1'b0;
    repeat (5) @(negedge core_clk);
    rst_n = 1'b1;
    t_reset;
    t_regs;
    t_mode;
    t_ignore;
    t_preset;
    t_fail;
    t_limit;
    t_index;
    t_switch;
    wrap_up;
  end
endmodule
